// ===== design/srsf_pkg.sv
// Constants for the security register read, software reset and parameter header slice.
// Assumes a serial flash front end with chip select, serial clock, serial in and out.
package srsf_pkg;
	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_SEC_READ = 8'h48;
	localparam logic [7:0] OP_RST_EN = 8'h66;
	localparam logic [7:0] OP_RST = 8'h99;
	localparam logic [7:0] OP_SFDP = 8'h5a;
	// ------------------------------------------------------------
	// Frame bit positions
	// ------------------------------------------------------------
	localparam logic [5:0] BIT_FIRST = 6'h00;
	localparam logic [5:0] CMD_LAST = 6'h07;
	localparam logic [5:0] CMD_OVER = 6'h08;
	localparam logic [5:0] ADDR_LAST = 6'h1f;
	localparam logic [5:0] DUMMY_LAST = 6'h27;
	localparam logic [5:0] DATA_PHASE = 6'h28;
	localparam logic [2:0] BYTE_LAST_BIT = 3'h7;
	// ------------------------------------------------------------
	// Security register address layout
	// ------------------------------------------------------------
	localparam logic [7:0] SEC_HI_OK = 8'h00;
	localparam logic [3:0] SEC_SEL_MIN = 4'h1;
	localparam logic [3:0] SEC_SEL_MAX = 4'h3;
	localparam logic [1:0] SEC_GAP_OK = 2'h0;
	localparam int SEC_OFF_W = 10;
	localparam int SEC_REGS = 3;
	localparam int SEC_TOTAL = SEC_REGS * 1024;
	localparam logic [9:0] SEC_OFF_LAST = 10'h3ff;
	localparam logic [9:0] SEC_OFF_FIRST = 10'h000;
	// ------------------------------------------------------------
	// Parameter table header
	// ------------------------------------------------------------
	localparam logic [23:0] SFDP_HDR_LEN = 24'h000018;
	localparam logic [4:0] SFDP_MFR_IDX = 5'h10;
	localparam logic [7:0] SFDP_FILL = 8'hff;
	localparam logic [7:0] SFDP_HDR [0:23] = '{
		8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hff,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
		8'hff, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
	localparam logic [7:0] SFDP_SIG0 = 8'h53;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int RST_CNT_W = 20;
	typedef enum logic [1:0] {SRSF_IDLE, SRSF_SEC, SRSF_SFDP} srsf_mode_t;
endpackage

// ===== design/srsf_core.sv
// Security register read, two-frame software reset and parameter header read.
// Assumes the host stops the serial clock whenever chip select is high.
`timescale 1ns/1ps

module srsf_core #(
	parameter int T_RST_NS = 30000,
	parameter logic [7:0] MFR_ID = 8'h5e // Arbitrary value
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic sclk_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	input wire logic op_start_i,
	input wire logic op_done_i,
	input wire logic susp_req_i,
	input wire logic resume_req_i,
	input wire logic wel_set_i,
	input wire logic wel_clr_i,
	input wire logic vstat_load_i,
	input wire logic [7:0] vstat_data_i,
	input wire logic rparam_load_i,
	input wire logic [7:0] rparam_data_i,
	input wire logic mode_load_i,
	input wire logic [7:0] mode_data_i,
	input wire logic wrap_load_i,
	input wire logic [2:0] wrap_data_i,
	input wire logic otp_we_i,
	input wire logic [11:0] otp_addr_i,
	input wire logic [7:0] otp_data_i,
	output logic write_in_progress_o,
	output logic suspend_flag_o,
	output logic write_enable_latch_o,
	output logic [7:0] vstat_o,
	output logic [7:0] read_parameter_bits_o,
	output logic [7:0] continuous_read_mode_bits_o,
	output logic [2:0] wrap_setting_bits_o,
	output logic abort_o,
	output logic reset_busy_o
);
	import srsf_pkg::*;

	localparam int RST_CYC = (T_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	if (RST_CYC < 9 || RST_CYC >= (1 << RST_CNT_W))
	begin : g_chk
		$error("T_RST_NS out of range");
	end

	// ------------------------------------------------------------
	// Security register storage, filled by the factory port
	// ------------------------------------------------------------
	logic [7:0] otp_mem [0:SEC_TOTAL-1];

	always_ff @(posedge clk_i)
	begin
		if (otp_we_i && otp_addr_i < 12'(SEC_TOTAL))
		begin
			otp_mem[otp_addr_i] <= otp_data_i;
		end
	end

	// ------------------------------------------------------------
	// Link side, on the serial clock
	// ------------------------------------------------------------
	// Chip select clears the frame state without any clock edge,
	// since the serial clock is stopped between frames.
	logic [5:0] cnt_reg, cnt_next;
	srsf_mode_t mode_reg, mode_next;
	logic [2:0] bidx_reg, bidx_next;
	logic bsy_s1_reg, bsy_s2_reg;
	logic [6:0] sh_reg, sh_next;
	logic [23:0] addr_reg, addr_next;
	logic [7:0] byte_reg, byte_next;
	logic [7:0] op_reg, op_next;
	logic full_reg, full_next;
	logic extra_reg, extra_next;
	logic so_reg, so_next;
	logic drv_reg, drv_next;
	logic busy_reg;

	wire logic [7:0] op_now = {sh_reg, si_i};
	wire logic in_data = cnt_reg == DATA_PHASE;
	wire logic at_cmd = cnt_reg == CMD_LAST;
	wire logic in_addr = cnt_reg >= CMD_OVER && cnt_reg <= ADDR_LAST;
	wire logic byte_end = in_data && bidx_reg == BYTE_LAST_BIT;
	wire logic fetch = cnt_reg == DUMMY_LAST || byte_end;
	wire logic [9:0] off_inc = addr_reg[9:0] + 10'h001;
	wire logic [23:0] addr_inc = (mode_reg == SRSF_SEC) ?
		{addr_reg[23:10], off_inc} : addr_reg + 24'h000001;
	wire logic [3:0] sel_n = addr_next[15:12];
	wire logic sec_ok = addr_next[23:16] == SEC_HI_OK && sel_n >= SEC_SEL_MIN
		&& sel_n <= SEC_SEL_MAX && addr_next[11:10] == SEC_GAP_OK;
	wire logic [1:0] sel_idx = sel_n[1:0] - 2'h1;
	wire logic [11:0] mem_idx = {sel_idx, addr_next[9:0]};
	wire logic [4:0] hdr_idx = addr_next[4:0];
	wire logic in_hdr = addr_next < SFDP_HDR_LEN;
	wire logic [7:0] sfdp_val = !in_hdr ? SFDP_FILL :
		(hdr_idx == SFDP_MFR_IDX) ? MFR_ID : SFDP_HDR[hdr_idx];
	wire logic [7:0] sec_val = sec_ok ? otp_mem[mem_idx] : SFDP_FILL;

	always_comb
	begin
		mode_next = mode_reg;
		if (at_cmd)
		begin
			// Commands are dropped while reset recovery runs
			if (bsy_s2_reg)
				mode_next = SRSF_IDLE;
			else if (op_now == OP_SEC_READ)
				mode_next = SRSF_SEC;
			else if (op_now == OP_SFDP)
				mode_next = SRSF_SFDP;
			else
				mode_next = SRSF_IDLE;
		end
		else if (cnt_reg == DUMMY_LAST && mode_reg == SRSF_SEC && !sec_ok)
		begin
			mode_next = SRSF_IDLE;
		end
	end

	assign cnt_next = in_data ? cnt_reg : cnt_reg + 6'h01;
	assign bidx_next = in_data ? bidx_reg + 3'h1 : 3'h0;
	assign sh_next = {sh_reg[5:0], si_i};
	assign addr_next = in_addr ? {addr_reg[22:0], si_i} :
		(byte_end ? addr_inc : addr_reg);
	assign byte_next = !fetch ? byte_reg :
		(mode_reg == SRSF_SEC ? sec_val : sfdp_val);
	assign op_next = at_cmd ? op_now : op_reg;
	assign full_next = (cnt_reg == BIT_FIRST) ? 1'b0 : (at_cmd ? 1'b1 : full_reg);
	assign extra_next = (cnt_reg == BIT_FIRST) ? 1'b0 :
		(cnt_reg == CMD_OVER ? 1'b1 : extra_reg);

	always_ff @(posedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			cnt_reg <= BIT_FIRST;
			mode_reg <= SRSF_IDLE;
			bidx_reg <= 3'h0;
			bsy_s1_reg <= 1'b0;
			bsy_s2_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			mode_reg <= mode_next;
			bidx_reg <= bidx_next;
			bsy_s1_reg <= busy_reg;
			bsy_s2_reg <= bsy_s1_reg;
		end
	end

	always_ff @(posedge sclk_i)
	begin
		sh_reg <= sh_next;
		addr_reg <= addr_next;
		byte_reg <= byte_next;
		op_reg <= op_next;
		full_reg <= full_next;
		extra_reg <= extra_next;
	end

	// ------------------------------------------------------------
	// Output shifter on the falling edge
	// ------------------------------------------------------------
	assign drv_next = in_data && mode_reg != SRSF_IDLE;
	assign so_next = byte_reg[BYTE_LAST_BIT - bidx_reg];

	always_ff @(negedge sclk_i or posedge cs_n_i)
	begin
		if (cs_n_i)
		begin
			so_reg <= 1'b0;
			drv_reg <= 1'b0;
		end
		else
		begin
			so_reg <= so_next;
			drv_reg <= drv_next;
		end
	end

	assign so_o = so_reg;
	assign so_oe_o = drv_reg;

	// ------------------------------------------------------------
	// System side: frame end, reset sequence, status
	// ------------------------------------------------------------
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic armed_reg, armed_next;
	logic [RST_CNT_W-1:0] rcnt_reg, rcnt_next;
	logic busy_next;
	logic abort_reg;
	logic wip_reg, wip_next;
	logic susp_reg, susp_next;
	logic wel_reg, wel_next;
	logic [7:0] vstat_reg, vstat_next;
	logic [7:0] rparam_reg, rparam_next;
	logic [7:0] cmode_reg, cmode_next;
	logic [2:0] wrap_reg, wrap_next;

	// Frame summary is quasi-static once chip select is high, so it
	// is safe to read two system clocks after the synchronised edge.
	wire logic frame_end = cs_s2_reg && !cs_s3_reg;
	wire logic frame_take = frame_end && !busy_reg;
	wire logic op_only = full_reg && !extra_reg;
	wire logic sw_reset = frame_take && armed_reg && op_only && op_reg == OP_RST;
	wire logic susp_ok = susp_req_i && wip_reg && !susp_reg;
	wire logic res_ok = resume_req_i && susp_reg && !wip_reg;

	assign armed_next = frame_take ? (op_only && op_reg == OP_RST_EN) : armed_reg;
	assign rcnt_next = sw_reset ? RST_CNT_W'(RST_CYC) :
		(rcnt_reg != '0 ? rcnt_reg - 1'b1 : rcnt_reg);
	assign busy_next = rcnt_next != '0;
	assign wip_next = sw_reset ? 1'b0 : susp_ok ? 1'b0 : res_ok ? 1'b1 :
		op_start_i ? 1'b1 : op_done_i ? 1'b0 : wip_reg;
	assign susp_next = sw_reset ? 1'b0 : susp_ok ? 1'b1 :
		res_ok ? 1'b0 : susp_reg;
	assign wel_next = sw_reset ? 1'b0 : wel_set_i ? 1'b1 :
		wel_clr_i ? 1'b0 : wel_reg;
	assign vstat_next = sw_reset ? 8'h00 : vstat_load_i ? vstat_data_i : vstat_reg;
	assign rparam_next = sw_reset ? 8'h00 : rparam_load_i ? rparam_data_i : rparam_reg;
	assign cmode_next = sw_reset ? 8'h00 : mode_load_i ? mode_data_i : cmode_reg;
	assign wrap_next = sw_reset ? 3'h0 : wrap_load_i ? wrap_data_i : wrap_reg;

	always_ff @(posedge clk_i)
	begin
		cs_s1_reg <= cs_n_i;
		cs_s2_reg <= cs_s1_reg;
		if (rst_i)
		begin
			cs_s3_reg <= 1'b1;
			armed_reg <= 1'b0;
			rcnt_reg <= '0;
			busy_reg <= 1'b0;
			abort_reg <= 1'b0;
			wip_reg <= 1'b0;
			susp_reg <= 1'b0;
			wel_reg <= 1'b0;
			vstat_reg <= 8'h00;
			rparam_reg <= 8'h00;
			cmode_reg <= 8'h00;
			wrap_reg <= 3'h0;
		end
		else
		begin
			cs_s3_reg <= cs_s2_reg;
			armed_reg <= armed_next;
			rcnt_reg <= rcnt_next;
			busy_reg <= busy_next;
			abort_reg <= sw_reset;
			wip_reg <= wip_next;
			susp_reg <= susp_next;
			wel_reg <= wel_next;
			vstat_reg <= vstat_next;
			rparam_reg <= rparam_next;
			cmode_reg <= cmode_next;
			wrap_reg <= wrap_next;
		end
	end

	assign write_in_progress_o = wip_reg;
	assign suspend_flag_o = susp_reg;
	assign write_enable_latch_o = wel_reg;
	assign vstat_o = vstat_reg;
	assign read_parameter_bits_o = rparam_reg;
	assign continuous_read_mode_bits_o = cmode_reg;
	assign wrap_setting_bits_o = wrap_reg;
	assign abort_o = abort_reg;
	assign reset_busy_o = busy_reg;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_reset_taken;
		sw_reset;
	endsequence

	sequence s_state_cleared;
		!wip_reg && !susp_reg && !wel_reg && rparam_reg == 8'h00 && wrap_reg == 3'h0;
	endsequence

	a_reset_clears_state: assert property (s_reset_taken |=> s_state_cleared)
		else $error("volatile state not cleared by reset");
	a_recovery_busy: assert property (s_reset_taken |=> busy_reg [*8])
		else $error("recovery window too short");
	a_busy_no_reset: assert property (busy_reg |=> !abort_reg)
		else $error("reset taken during recovery");
	a_suspend_sets: assert property (susp_ok && !sw_reset |=> susp_reg && !wip_reg)
		else $error("suspend flag not set on suspend");
	a_wip_follows_op: assert property (op_start_i && !sw_reset && !susp_ok && !res_ok
		|=> wip_reg)
		else $error("write in progress not set");
	a_wel_kept: assert property (!wel_set_i && !wel_clr_i && !sw_reset |=> $stable(wel_reg))
		else $error("write enable latch changed");
	a_release_cs: assert property (cs_n_i |-> !so_oe_o)
		else $error("output driven without chip select");
	a_offset_wrap: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		byte_end && mode_reg == SRSF_SEC && addr_reg[9:0] == SEC_OFF_LAST
		|=> addr_reg[9:0] == SEC_OFF_FIRST && addr_reg[23:10] == $past(addr_reg[23:10]))
		else $error("offset did not wrap");
	a_sfdp_advance: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		byte_end && mode_reg == SRSF_SFDP |=> addr_reg == $past(addr_reg) + 24'h000001)
		else $error("table address did not advance");
	a_sfdp_sig: assert property (@(posedge sclk_i) disable iff (cs_n_i)
		cnt_reg == DUMMY_LAST && mode_reg == SRSF_SFDP && addr_next == 24'h000000
		|=> byte_reg == SFDP_SIG0)
		else $error("signature byte wrong");
endmodule

// ===== bench/srsf_host_model.sv
// Host controller model: drives chip select, serial clock and serial input.
// Assumes the device samples input on rising edges and shifts output on falling edges.
`timescale 1ns/1ps
module srsf_host_model (
	output logic sclk_o,
	output logic cs_n_o,
	output logic si_o,
	input wire logic so_i,
	input wire logic so_oe_i
);
	// ------------------------------------------------------------
	// Captured read data
	// ------------------------------------------------------------
	logic [7:0] rd [0:7];
	logic oe_all;
	logic oe_any;
	initial
	begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b1;
	end
	// ------------------------------------------------------------
	// One frame; clock stands still outside it
	// ------------------------------------------------------------
	task automatic xfer(input logic [7:0] op, input logic [23:0] a, input int nhdr, input int nbytes);
		logic [39:0] hdr;
		hdr = {op, a, 8'ha5};
		oe_all = 1'b1;
		oe_any = 1'b0;
		cs_n_o = 1'b0;
		for (int i = 0; i < nhdr; i++)
		begin
			si_o = hdr[39 - i];
			#6;
			sclk_o = 1'b1;
			#6;
			sclk_o = 1'b0;
		end
		for (int i = 0; i < nbytes * 8; i++)
		begin
			si_o = ~si_o;
			#6;
			sclk_o = 1'b1;
			rd[i / 8] = {rd[i / 8][6:0], so_i};
			oe_all = oe_all & so_oe_i;
			oe_any = oe_any | so_oe_i;
			#6;
			sclk_o = 1'b0;
		end
		#6;
		cs_n_o = 1'b1;
		si_o = ~si_o;
		// Gap long enough for the system clock side to see the frame end
		#60;
	endtask
endmodule

// ===== bench/tb_secreg_read_reset_sfdp.sv
// Self-checking bench for the security read, software reset and table header slice.
// Assumes srsf_core with a shortened reset recovery time.
`timescale 1ns/1ps
module tb_secreg_read_reset_sfdp;
	import srsf_pkg::*;
	localparam logic [7:0] MFR = 8'h3c; // Arbitrary value
	localparam logic [7:0] HDR [0:23] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01,
		8'hff, 8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hff,
		MFR, 8'h00, 8'h01, 8'h03, 8'h60, 8'h00, 8'h00, 8'hff};
	typedef struct {logic [7:0] op; logic [23:0] a; int n; bit ok;} srsf_row_t;
	srsf_row_t rows [0:11] = '{'{OP_SEC_READ, 24'h001000, 2, 1},
		'{OP_SEC_READ, 24'h0023fe, 3, 1}, '{OP_SEC_READ, 24'h003155, 2, 1},
		'{OP_SEC_READ, 24'h011000, 1, 0}, '{OP_SEC_READ, 24'h000000, 1, 0},
		'{OP_SEC_READ, 24'h004000, 1, 0}, '{OP_SEC_READ, 24'h001400, 1, 0},
		'{8'h03, 24'h001000, 1, 0}, '{OP_SFDP, 24'h000000, 8, 1},
		'{OP_SFDP, 24'h000008, 8, 1}, '{OP_SFDP, 24'h000010, 8, 1}, '{OP_SFDP, 24'h000016, 3, 1}};
	logic clk_i, rst_i, otp_we_i;
	logic [9:0] stb;
	logic [7:0] vd, rpd, md, otp_data_i;
	logic [2:0] wd;
	logic [11:0] otp_addr_i;
	wire logic sclk_i, cs_n_i, si_i, so_o, so_oe_o, write_in_progress, susp, write_enable_latch, abort_o, busy;
	wire logic [7:0] vstat_o, rparam_o, mode_o;
	wire logic [2:0] wrap_o;
	int error_cnt = 0;
	int checked = 0;
	int abort_cnt = 0;
	int w;
	srsf_core #(.T_RST_NS(2000), .MFR_ID(MFR)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.sclk_i(sclk_i), .cs_n_i(cs_n_i), .si_i(si_i), .so_o(so_o), .so_oe_o(so_oe_o),
		.op_start_i(stb[0]), .op_done_i(stb[1]), .susp_req_i(stb[2]), .resume_req_i(stb[3]),
		.wel_set_i(stb[4]), .wel_clr_i(stb[5]), .vstat_load_i(stb[6]), .vstat_data_i(vd),
		.rparam_load_i(stb[7]), .rparam_data_i(rpd), .mode_load_i(stb[8]), .mode_data_i(md),
		.wrap_load_i(stb[9]), .wrap_data_i(wd), .otp_we_i(otp_we_i), .otp_addr_i(otp_addr_i),
		.otp_data_i(otp_data_i), .write_in_progress_o(write_in_progress), .suspend_flag_o(susp),
		.write_enable_latch_o(write_enable_latch), .vstat_o(vstat_o), .read_parameter_bits_o(rparam_o),
		.continuous_read_mode_bits_o(mode_o), .wrap_setting_bits_o(wrap_o),
		.abort_o(abort_o), .reset_busy_o(busy));
	srsf_host_model host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .si_o(si_i), .so_i(so_o),
		.so_oe_i(so_oe_o));
	initial
	begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
		if (abort_o === 1'b1)
			abort_cnt <= abort_cnt + 1;
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] pat(input logic [11:0] i);
		return i[7:0] ^ {i[11:8], 4'h9};
	endfunction
	function automatic logic [7:0] expv(input logic [7:0] op, input logic [23:0] a, input int k);
		logic [9:0] off;
		logic [7:0] t;
		off = a[9:0] + k[9:0];
		t = a[7:0] + k[7:0];
		if (op == OP_SEC_READ)
			return pat({a[13:12] - 2'h1, off});
		return (t < 8'h18) ? HDR[t] : 8'hff;
	endfunction
	task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
		checked++;
		if (got !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask
	// One strobe high for one cycle, then let the registered answer land
	task automatic pulse(input int b);
		@(posedge clk_i);
		stb[b] <= 1'b1;
		@(posedge clk_i);
		stb <= 10'h000;
		repeat (2) @(posedge clk_i);
		#1;
	endtask
	task automatic final_report;
		$display("Checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		rst_i = 1'b1;
		stb = 10'h000;
		{vd, rpd, md, wd} = 27'h0;
		{otp_we_i, otp_addr_i, otp_data_i} = 21'h0;
		// Two edges so the chip select synchroniser settles
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < SEC_TOTAL; i++)
		begin
			@(posedge clk_i);
			otp_we_i <= 1'b1;
			otp_addr_i <= i[11:0];
			otp_data_i <= pat(i[11:0]);
		end
		@(posedge clk_i);
		otp_we_i <= 1'b0;
		pulse(4);
		foreach (rows[r])
		begin
			host.xfer(rows[r].op, rows[r].a, 40, rows[r].n);
			chk("so_oe_o idle", 12'h000, {11'h0, so_oe_o});
			if (rows[r].ok)
				chk("so_oe_o data", 12'h001, {11'h0, host.oe_all});
			else
				chk("so_oe_o refused", 12'h000, {11'h0, host.oe_any});
			for (int k = 0; k < rows[r].n && rows[r].ok; k++)
				chk("so_o byte", {4'h0, expv(rows[r].op, rows[r].a, k)}, {4'h0, host.rd[k]});
		end
		chk("wel wip after reads", 12'h002, {10'h0, write_enable_latch, write_in_progress});
		pulse(5);
		chk("wel cleared", 12'h000, {11'h0, write_enable_latch});
		pulse(2);
		chk("suspend idle", 12'h000, {11'h0, susp});
		pulse(0);
		chk("wip set", 12'h001, {11'h0, write_in_progress});
		pulse(2);
		chk("suspend set", 12'h001, {11'h0, susp});
		pulse(3);
		chk("resume", 12'h002, {10'h0, write_in_progress, susp});
		pulse(1);
		chk("wip done", 12'h000, {11'h0, write_in_progress});
		// Load every volatile item but write in progress, which the suspend clears, so the reset has something to clear
		vd <= 8'ha5;
		rpd <= 8'h3c;
		md <= 8'hc3;
		wd <= 3'h5;
		for (int b = 0; b < 10; b++)
			if (b != 1 && b != 3 && b != 5)
				pulse(b);
		chk("suspend before reset", 12'h001, {11'h0, susp});
		chk("vstat loaded", 12'h0a5, {4'h0, vstat_o});
		chk("rparam loaded", 12'h03c, {4'h0, rparam_o});
		chk("mode wrap loaded", 12'h5c3, {1'b0, wrap_o, mode_o});
		w = abort_cnt;
		host.xfer(OP_RST_EN, 24'h0, 8, 0);
		host.xfer(OP_SEC_READ, 24'h001000, 40, 1);
		host.xfer(OP_RST, 24'h0, 8, 0);
		chk("reset arm broken", 12'h000, abort_cnt[11:0] - w[11:0]);
		host.xfer(OP_RST_EN, 24'h0, 8, 0);
		host.xfer(OP_RST, 24'h0, 8, 0);
		repeat (5) @(posedge clk_i);
		#1;
		chk("abort pulses", 12'h001, abort_cnt[11:0] - w[11:0]);
		chk("flags", 12'h008, {8'h0, busy, write_in_progress, susp, write_enable_latch});
		chk("settings", 12'h000, {vstat_o | rparam_o | mode_o, 1'b0, wrap_o});
		host.xfer(OP_SFDP, 24'h0, 40, 1);
		chk("read in recovery", 12'h000, {11'h0, host.oe_any});
		// A full reset pair inside the recovery window must be dropped
		host.xfer(OP_RST_EN, 24'h0, 8, 0);
		host.xfer(OP_RST, 24'h0, 8, 0);
		chk("reset in recovery", 12'h001, abort_cnt[11:0] - w[11:0]);
		for (w = 0; w < 400 && busy !== 1'b0; w++)
			@(posedge clk_i);
		if (w == 400)
		begin
			$display("Error reset_busy_o expected 0 seen %b", busy);
			error_cnt++;
		end
		else
		begin
			host.xfer(OP_SFDP, 24'h0, 40, 1);
			chk("read after recovery", {4'h0, HDR[0]}, {4'h0, host.rd[0]});
		end
		final_report;
	end
endmodule
